// *** src/clk_osc_cfg.svh ***
// Purpose: Offsets, field positions, reset values and counts for the clock and oscillator control block
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one register per aligned word
// Notes:   Definitions only
`ifndef CLK_OSC_CFG_SVH
`define CLK_OSC_CFG_SVH

`define ADDR_W               8
`define OFS_SYSCLK_SELECT    8'h00
`define OFS_FAST_RC_CTRL     8'h04
`define OFS_FAST_XTAL_CTRL   8'h08
`define OFS_SLOW_XTAL_CTRL   8'h0c
`define OFS_IRQ_STATUS       8'h10
`define OFS_IRQ_MASK         8'h14

// System clock select fields
`define SYSCLK_SEL_MSB       7
`define SYSCLK_SEL_LSB       5
`define FAST_SRC_BIT         3
`define SLOW_SRC_BIT         2
`define HALT_FAST_KEEP_BIT   1
`define HALT_SLOW_KEEP_BIT   0
`define SYSCLK_SUB_CODE      3'h7
`define SYSCLK_SELECT_RST    8'h00

// Oscillator control fields
`define OSC_EN_BIT           0
`define OSC_STABLE_BIT       1
`define RC_FREQ_MSB          3
`define RC_FREQ_LSB          2
`define XTAL_MODE_BIT        2
`define RC_FREQ_RST          2'h0
`define FAST_RC_EN_RST       1'b1
`define FAST_XTAL_EN_RST     1'b0
`define XTAL_MODE_RST        1'b0
`define SLOW_XTAL_EN_RST     1'b0

// Interrupt fields
`define IRQ_W                3
`define IRQ_MASK_RST         3'h0

// Oscillator cycles counted before a stable flag rises
`define FAST_RC_STABLE_CYC   16'd256
`define FAST_XTAL_STABLE_CYC 16'd1024
`define SLOW_XTAL_STABLE_CYC 16'd1024

`endif

// *** src/clk_osc_pkg.sv ***
// Purpose: Types shared by the clock and oscillator control block
// Assumes: Offsets and field positions come from clk_osc_cfg.svh
// Notes:   Types only
package clk_osc_pkg;

   typedef enum logic [2:0] {
      REG_SYSCLK_SELECT = 3'b000,
      REG_FAST_RC_CTRL  = 3'b001,
      REG_FAST_XTAL     = 3'b010,
      REG_SLOW_XTAL     = 3'b011,
      REG_IRQ_STATUS    = 3'b100,
      REG_IRQ_MASK      = 3'b101,
      REG_NONE          = 3'b111
   } reg_sel_t;

   typedef enum logic [1:0] {
      BUS_IDLE  = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ  = 2'b10
   } bus_state_t;

   typedef enum logic [1:0] {
      RC_4MHZ  = 2'b00,
      RC_8MHZ  = 2'b01,
      RC_12MHZ = 2'b10,
      RC_4MHZ_ALT = 2'b11
   } rc_freq_t;

endpackage : clk_osc_pkg

// *** src/osc_if.sv ***
// Purpose: Carries one oscillator's run request, cycle ticks and stable flag
// Assumes: Ticks are one-cycle pulses synchronous to hclk
// Notes:   ctrl side drives run and tick, mon side answers
`timescale 1ns/10ps
interface osc_if;
   logic run;
   logic tick;
   logic stable;
   logic stable_rise;

   modport ctrl (output run, output tick, input stable, input stable_rise);
   modport mon  (input run, input tick, output stable, output stable_rise);
endinterface : osc_if

// *** src/osc_stable_counter.sv ***
// Purpose: Stable flag for one oscillator, counted in its own cycles
// Assumes: osc.tick pulses once per oscillator cycle while running
// Notes:   Flag clears in the cycle after run falls
`timescale 1ns/10ps
module osc_stable_counter
   import clk_osc_pkg::*;
#(
   parameter logic [15:0] COUNT = 16'd16
) (
   input wire logic hclk,
   input wire logic hresetn,
   osc_if.mon       osc
);

   logic [15:0] cnt_q;
   logic        stable_q;
   logic        rise_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q    <= 16'h0000;
         stable_q <= 1'b0;
      end else if (!osc.run) begin
         cnt_q    <= 16'h0000; // [R17]
         stable_q <= 1'b0;     // [R17]
      end else if (osc.tick && !stable_q) begin
         if (cnt_q == COUNT - 16'd1) begin
            stable_q <= 1'b1;  // [R17]
         end else begin
            cnt_q <= cnt_q + 16'd1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rise_q <= 1'b0;
      end else begin
         rise_q <= osc.run && osc.tick && !stable_q && (cnt_q == COUNT - 16'd1);
      end
   end

   assign osc.stable      = stable_q;
   assign osc.stable_rise = rise_q;

endmodule : osc_stable_counter

// *** src/system_clock_osc_control.sv ***
// Purpose: System clock selection and oscillator control behind an AHB-Lite register slave
// Assumes: Oscillator ticks, halt and watchdog enable are synchronous to hclk
// Notes:   Reads take one wait state, writes none; response always OKAY
`timescale 1ns/10ps
`include "clk_osc_cfg.svh"

// Functional notes
// R1 - Select codes 0-6 give fast clock divided 1..64; code 7 gives sub clock.
// R2 - Fast source bit picks internal fast RC at 0, external fast crystal at 1.
// R3 - Slow source bit picks internal slow RC at 0, external slow crystal at 1.
// R4 - During halt the fast oscillator runs only if the halt fast keep bit is 1.
// R5 - During halt the slow oscillator runs only if the halt slow keep bit is 1.
// R6 - Internal slow RC keeps running in halt whenever the watchdog is enabled.
// R7 - RC frequency field: 00 4MHz, 01 8MHz, 10 12MHz, 11 4MHz.
// R8 - Enabling the internal fast RC clears its stable flag, then sets it when stable.
// R9 - Internal fast RC enable turns it on or off and resets to 1.
// R10 - Crystal mode bit: 0 for crystals up to 10MHz, 1 above 10MHz.
// R11 - Software sets crystal mode before enabling and never changes it while enabled.
// R12 - Enabling the fast crystal clears its stable flag, then sets it when stable.
// R13 - Fast crystal enable turns it on or off and resets to 0.
// R14 - Unused upper bits and system clock bit 4 ignore writes and read 0.
// R15 - Enabling the slow crystal clears its stable flag, then sets it when stable.
// R16 - Halt with both keep bits 0 enters deep power-down and stops the peripheral sub clock.
// R17 - Stable flags count fixed oscillator cycles after enable and clear when it stops.
module system_clock_osc_control
   import clk_osc_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   input  wire logic        internal_fast_rc_tick,
   input  wire logic        external_fast_crystal_tick,
   input  wire logic        internal_slow_rc_tick,
   input  wire logic        external_slow_crystal_tick,
   input  wire logic        halt_active,
   input  wire logic        wdt_enable,
   output logic             internal_fast_rc_run,
   output logic             external_fast_crystal_run,
   output logic             internal_slow_rc_run,
   output logic             external_slow_crystal_run,
   output logic [1:0]       int_rc_freq_select,
   output logic             crystal_range_mode,
   output logic             fast_clock_tick,
   output logic             sub_clock_tick,
   output logic             periph_sub_clock_tick,
   output logic             sys_clock_tick,
   output logic             deep_power_down
);

   // Maps a word address to a register
   function automatic reg_sel_t reg_decode(input logic [`ADDR_W-1:0] a);
      reg_sel_t s;
      s = REG_NONE;
      if (a == `OFS_SYSCLK_SELECT) begin
         s = REG_SYSCLK_SELECT;
      end else if (a == `OFS_FAST_RC_CTRL) begin
         s = REG_FAST_RC_CTRL;
      end else if (a == `OFS_FAST_XTAL_CTRL) begin
         s = REG_FAST_XTAL;
      end else if (a == `OFS_SLOW_XTAL_CTRL) begin
         s = REG_SLOW_XTAL;
      end else if (a == `OFS_IRQ_STATUS) begin
         s = REG_IRQ_STATUS;
      end else if (a == `OFS_IRQ_MASK) begin
         s = REG_IRQ_MASK;
      end
      return s;
   endfunction : reg_decode

   // Bus phase tracking
   bus_state_t             bus_q;
   logic [`ADDR_W-1:0]     addr_q;
   logic [31:0]            hrdata_q;
   logic                   addr_take;
   reg_sel_t               sel_data;

   // Control registers
   logic [2:0]             sysclk_select_q;
   logic                   fast_source_select_q;
   logic                   slow_source_select_q;
   logic                   halt_fast_keep_q;
   logic                   halt_slow_keep_q;
   logic [1:0]             int_rc_freq_select_q;
   logic                   int_rc_enable_q;
   logic                   crystal_range_mode_q;
   logic                   fast_crystal_enable_q;
   logic                   slow_crystal_enable_q;
   logic [`IRQ_W-1:0]      irq_status_q;
   logic [`IRQ_W-1:0]      irq_mask_q;

   // Oscillator side
   logic                   int_rc_stable;
   logic                   fast_crystal_stable;
   logic                   slow_crystal_stable;
   logic [`IRQ_W-1:0]      stable_rise;
   logic [`IRQ_W-1:0]      osc_run;
   logic [`IRQ_W-1:0]      osc_tick;
   logic [`IRQ_W-1:0]      osc_stable;
   logic                   fast_keep;
   logic                   slow_keep;
   logic                   fast_sel_tick;
   logic                   sub_sel_tick;
   logic [5:0]             div_cnt_q;
   logic [5:0]             div_mask;
   logic                   sys_tick_q;
   logic                   fast_tick_q;
   logic                   sub_tick_q;
   logic                   periph_sub_q;

   logic                   wr_commit;
   logic                   rd_commit;
   logic [7:0]             wbyte;

   assign addr_take = hsel && hready && htrans[1];
   assign sel_data  = reg_decode(addr_q);
   assign wr_commit = (bus_q == BUS_WRITE);
   assign rd_commit = (bus_q == BUS_READ);
   assign wbyte     = hwdata[7:0];

   assign hreadyout = !rd_commit;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   // AHB-Lite phase tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_q  <= BUS_IDLE;
         addr_q <= '0;
      end else begin
         case (bus_q)
            BUS_READ: begin
               bus_q <= BUS_IDLE;
            end
            default: begin
               if (addr_take) begin
                  bus_q  <= hwrite ? BUS_WRITE : BUS_READ;
                  addr_q <= {haddr[`ADDR_W-1:2], 2'b00};
               end else begin
                  bus_q <= BUS_IDLE;
               end
            end
         endcase
      end
   end

   // Register read data, captured in the wait cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rd_commit) begin
         if (sel_data == REG_SYSCLK_SELECT) begin
            hrdata_q <= {24'h000000, sysclk_select_q, 1'b0, fast_source_select_q, // [R14]
                         slow_source_select_q, halt_fast_keep_q, halt_slow_keep_q};
         end else if (sel_data == REG_FAST_RC_CTRL) begin
            hrdata_q <= {28'h0000000, int_rc_freq_select_q, int_rc_stable, int_rc_enable_q}; // [R14]
         end else if (sel_data == REG_FAST_XTAL) begin
            hrdata_q <= {29'h00000000, crystal_range_mode_q, fast_crystal_stable, // [R14]
                         fast_crystal_enable_q};
         end else if (sel_data == REG_SLOW_XTAL) begin
            hrdata_q <= {30'h00000000, slow_crystal_stable, slow_crystal_enable_q}; // [R14]
         end else if (sel_data == REG_IRQ_STATUS) begin
            hrdata_q <= {29'h00000000, irq_status_q};
         end else if (sel_data == REG_IRQ_MASK) begin
            hrdata_q <= {29'h00000000, irq_mask_q};
         end else begin
            hrdata_q <= 32'h0000_0000;
         end
      end
   end

   // System clock select register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sysclk_select_q      <= 3'(`SYSCLK_SELECT_RST >> `SYSCLK_SEL_LSB);
         fast_source_select_q <= 1'b0;
         slow_source_select_q <= 1'b0;
         halt_fast_keep_q     <= 1'b0;
         halt_slow_keep_q     <= 1'b0;
      end else if (wr_commit && sel_data == REG_SYSCLK_SELECT) begin
         sysclk_select_q      <= wbyte[`SYSCLK_SEL_MSB:`SYSCLK_SEL_LSB];
         fast_source_select_q <= wbyte[`FAST_SRC_BIT];
         slow_source_select_q <= wbyte[`SLOW_SRC_BIT];
         halt_fast_keep_q     <= wbyte[`HALT_FAST_KEEP_BIT];
         halt_slow_keep_q     <= wbyte[`HALT_SLOW_KEEP_BIT];
      end
   end

   // Internal fast RC control register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_rc_freq_select_q <= `RC_FREQ_RST;
         int_rc_enable_q      <= `FAST_RC_EN_RST; // [R9]
      end else if (wr_commit && sel_data == REG_FAST_RC_CTRL) begin
         int_rc_freq_select_q <= wbyte[`RC_FREQ_MSB:`RC_FREQ_LSB]; // [R7]
         int_rc_enable_q      <= wbyte[`OSC_EN_BIT];               // [R9]
      end
   end

   // Fast crystal control; mode held while the crystal is enabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         crystal_range_mode_q  <= `XTAL_MODE_RST;
         fast_crystal_enable_q <= `FAST_XTAL_EN_RST; // [R13]
      end else if (wr_commit && sel_data == REG_FAST_XTAL) begin
         if (!fast_crystal_enable_q) begin
            crystal_range_mode_q <= wbyte[`XTAL_MODE_BIT]; // [R10] [R11]
         end
         fast_crystal_enable_q <= wbyte[`OSC_EN_BIT];      // [R13]
      end
   end

   // Slow crystal control register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slow_crystal_enable_q <= `SLOW_XTAL_EN_RST;
      end else if (wr_commit && sel_data == REG_SLOW_XTAL) begin
         slow_crystal_enable_q <= wbyte[`OSC_EN_BIT];
      end
   end

   // Interrupt mask
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask_q <= `IRQ_MASK_RST;
      end else if (wr_commit && sel_data == REG_IRQ_MASK) begin
         irq_mask_q <= wbyte[`IRQ_W-1:0];
      end
   end

   // Sticky status, cleared by read; a new event wins over the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status_q <= '0;
      end else if (rd_commit && sel_data == REG_IRQ_STATUS) begin
         irq_status_q <= stable_rise;
      end else begin
         irq_status_q <= irq_status_q | stable_rise;
      end
   end

   assign irq = |(irq_status_q & irq_mask_q);

   // Halt keep decisions
   assign fast_keep = !halt_active || halt_fast_keep_q; // [R4]
   assign slow_keep = !halt_active || halt_slow_keep_q; // [R5]

   assign internal_fast_rc_run      = int_rc_enable_q && fast_keep;           // [R4] [R9]
   assign external_fast_crystal_run = fast_crystal_enable_q && fast_keep;     // [R4] [R13]
   assign external_slow_crystal_run = slow_crystal_enable_q && slow_keep;     // [R5]
   assign internal_slow_rc_run      = slow_keep || wdt_enable;               // [R5] [R6]
   assign deep_power_down = halt_active && !halt_fast_keep_q && !halt_slow_keep_q; // [R16]

   assign int_rc_freq_select = int_rc_freq_select_q; // [R7]
   assign crystal_range_mode = crystal_range_mode_q; // [R10]

   // Stable flag counters, one per oscillator with an enable bit
   assign osc_run  = {external_slow_crystal_run, external_fast_crystal_run, internal_fast_rc_run};
   assign osc_tick = {external_slow_crystal_tick, external_fast_crystal_tick, internal_fast_rc_tick};

   genvar gi;
   generate
      for (gi = 0; gi < `IRQ_W; gi++) begin : g_osc
         localparam logic [15:0] CYC = (gi == 0) ? `FAST_RC_STABLE_CYC :
                                       (gi == 1) ? `FAST_XTAL_STABLE_CYC : `SLOW_XTAL_STABLE_CYC;
         osc_if u_link ();
         assign u_link.run  = osc_run[gi];
         assign u_link.tick = osc_tick[gi];
         assign osc_stable[gi]  = u_link.stable;
         assign stable_rise[gi] = u_link.stable_rise;
         osc_stable_counter #(
            .COUNT (CYC)
         ) u_cnt (
            .hclk    (hclk),
            .hresetn (hresetn),
            .osc     (u_link.mon)
         );
      end
   endgenerate

   assign int_rc_stable       = osc_stable[0]; // [R8] [R17]
   assign fast_crystal_stable = osc_stable[1]; // [R12] [R17]
   assign slow_crystal_stable = osc_stable[2]; // [R15] [R17]

   // Source selection
   assign fast_sel_tick = fast_source_select_q ? (external_fast_crystal_tick && external_fast_crystal_run)
                                               : (internal_fast_rc_tick && internal_fast_rc_run); // [R2]
   assign sub_sel_tick  = slow_source_select_q ? (external_slow_crystal_tick && external_slow_crystal_run)
                                               : (internal_slow_rc_tick && internal_slow_rc_run); // [R3]

   // Divider mask for 1..64
   always_comb begin
      div_mask = 6'h00;
      case (sysclk_select_q)
         3'h1:    div_mask = 6'h01;
         3'h2:    div_mask = 6'h03;
         3'h3:    div_mask = 6'h07;
         3'h4:    div_mask = 6'h0f;
         3'h5:    div_mask = 6'h1f;
         3'h6:    div_mask = 6'h3f;
         default: div_mask = 6'h00;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_q <= 6'h00;
      end else if (fast_sel_tick) begin
         div_cnt_q <= div_cnt_q + 6'h01;
      end
   end

   // System clock tick; stopped while halted
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sys_tick_q <= 1'b0;
      end else if (halt_active) begin
         sys_tick_q <= 1'b0;
      end else if (sysclk_select_q == `SYSCLK_SUB_CODE) begin
         sys_tick_q <= sub_sel_tick; // [R1]
      end else begin
         sys_tick_q <= fast_sel_tick && ((div_cnt_q & div_mask) == div_mask); // [R1]
      end
   end

   // Fast, sub and peripheral sub clock ticks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_tick_q  <= 1'b0;
         sub_tick_q   <= 1'b0;
         periph_sub_q <= 1'b0;
      end else begin
         fast_tick_q  <= fast_sel_tick;
         sub_tick_q   <= sub_sel_tick;
         periph_sub_q <= sub_sel_tick && !deep_power_down && slow_keep; // [R16]
      end
   end

   assign sys_clock_tick        = sys_tick_q;
   assign fast_clock_tick       = fast_tick_q;
   assign sub_clock_tick        = sub_tick_q;
   assign periph_sub_clock_tick = periph_sub_q;

endmodule : system_clock_osc_control

// *** sim/clk_osc_properties.sv ***
// Purpose: Concurrent checks on the clock and oscillator control block ports
// Assumes: One hclk domain, hresetn asynchronous and active low
// Notes:   Bound to the top module at the foot of this file
`timescale 1ns/10ps
module clk_osc_properties (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       halt_active,
   input wire logic       wdt_enable,
   input wire logic       internal_fast_rc_run,
   input wire logic       external_fast_crystal_run,
   input wire logic       internal_slow_rc_run,
   input wire logic       external_slow_crystal_run,
   input wire logic       fast_clock_tick,
   input wire logic       sub_clock_tick,
   input wire logic       periph_sub_clock_tick,
   input wire logic       sys_clock_tick,
   input wire logic       deep_power_down
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read data phase without exactly one wait state");
   write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   resp_okay_a: assert property (hresp == 1'b0)
      else $error("error response seen");
   deep_fast_off_a: assert property (
      deep_power_down |-> !internal_fast_rc_run && !external_fast_crystal_run)
      else $error("fast oscillator running in deep power-down");
   slow_off_a: assert property (
      deep_power_down && !wdt_enable |-> !internal_slow_rc_run && !external_slow_crystal_run)
      else $error("slow oscillator running in deep power-down");
   awake_slow_rc_a: assert property (!halt_active |-> internal_slow_rc_run)
      else $error("internal slow rc stopped while awake");
   wdt_slow_rc_a: assert property (halt_active && wdt_enable |-> internal_slow_rc_run)
      else $error("internal slow rc stopped with watchdog enabled");
   deep_halt_a: assert property (deep_power_down |-> halt_active)
      else $error("deep power-down without halt");
   periph_stop_a: assert property (
      deep_power_down && $past(deep_power_down) |-> !periph_sub_clock_tick)
      else $error("peripheral sub clock ticking in deep power-down");
   halt_sys_stop_a: assert property (halt_active && $past(halt_active) |-> !sys_clock_tick)
      else $error("system clock ticking while halted");
   fast_idle_a: assert property (
      !internal_fast_rc_run && !external_fast_crystal_run |=> !fast_clock_tick)
      else $error("fast clock ticking with both fast sources stopped");
   sub_idle_a: assert property (
      !internal_slow_rc_run && !external_slow_crystal_run |=> !sub_clock_tick)
      else $error("sub clock ticking with both slow sources stopped");

   cover property (hsel && hready && htrans[1] && !hwrite);
   cover property (deep_power_down ##1 wdt_enable);
   cover property (sys_clock_tick);
endmodule : clk_osc_properties

bind system_clock_osc_control clk_osc_properties clk_osc_properties_inst (
   .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .halt_active,
   .wdt_enable, .internal_fast_rc_run, .external_fast_crystal_run, .internal_slow_rc_run,
   .external_slow_crystal_run, .fast_clock_tick, .sub_clock_tick, .periph_sub_clock_tick,
   .sys_clock_tick, .deep_power_down
);

// *** sim/test_system_clock_osc_control.sv ***
// Purpose: Register, oscillator, clock rate and halt tests over AHB-Lite
// Assumes: Bench models the four oscillators as tick pulses at three distinct rates
// Notes:   Single slave, so hready is the block's own hreadyout
`timescale 1ns/10ps
`include "clk_osc_cfg.svh"
module test_system_clock_osc_control;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        halt_active = 1'b0, wdt_enable = 1'b0, tick_on = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2, ph = 3'h0;
   logic [3:0]  tk = 4'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, sys_cnt = 32'h0, rd;
   logic [31:0] hrdata;
   logic [1:0]  int_rc_freq_select;
   logic        hreadyout, hresp, irq, internal_fast_rc_run, external_fast_crystal_run;
   logic        internal_slow_rc_run, external_slow_crystal_run, crystal_range_mode;
   logic        fast_clock_tick, sub_clock_tick, periph_sub_clock_tick, sys_clock_tick, deep_power_down;
   int          n_fail = 0, check_count = 0;

   system_clock_osc_control system_clock_osc_control_inst (.*, .hready(hreadyout),
      .internal_fast_rc_tick(tk[0]), .external_fast_crystal_tick(tk[1]),
      .internal_slow_rc_tick(tk[2]), .external_slow_crystal_tick(tk[3]));

   always #50 hclk = ~hclk;

   // Fast rc every 2 cycles, fast crystal and slow rc every 4, slow crystal every 8
   always @(posedge hclk) begin
      ph <= ph + 3'h1;
      tk <= tick_on ? {ph == 3'h6, ph[1:0] == 2'h2, ph[1:0] == 2'h0, ph[0] == 1'b0} : 4'h0;
      sys_cnt <= sys_cnt + {31'h0, sys_clock_tick};
   end

   task end_of_test;
      if (n_fail == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test

   task check(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : check

   task bchk(input logic got, input logic exp, input string m);
      check({31'h0, got}, {31'h0, exp}, m);
   endtask : bchk

   // Samples hready mid-cycle, returns just after the edge that takes it
   task wait_rdy;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
   endtask : wait_rdy

   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask : xfer

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
      xfer(1'b0, a, 32'h0);
      check(rd, exp, m);
   endtask : rchk

   task sysrate(input logic [7:0] system_clock_select, input logic [31:0] exp);
      logic [31:0] n0;
      wr(`OFS_SYSCLK_SELECT, {24'h0, system_clock_select});
      repeat (8) @(posedge hclk);
      n0 = sys_cnt;
      repeat (512) @(posedge hclk);
      check(sys_cnt - n0, exp, "system clock rate");
   endtask : sysrate

   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      end_of_test;
   end

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk(`OFS_SYSCLK_SELECT, 32'h0, "sysclk reset");
      rchk(`OFS_FAST_RC_CTRL, 32'h1, "fast rc reset");
      rchk(`OFS_FAST_XTAL_CTRL, 32'h0, "fast crystal reset");
      rchk(`OFS_SLOW_XTAL_CTRL, 32'h0, "slow crystal reset");
      rchk(8'h1c, 32'h0, "unmapped");
      wr(`OFS_SYSCLK_SELECT, 32'hff);
      rchk(`OFS_SYSCLK_SELECT, 32'hef, "sysclk reserved bit");
      for (int f = 0; f < 4; f++) begin
         wr(`OFS_FAST_RC_CTRL, {24'h0, 4'hf, 2'(f), 2'b01});
         rchk(`OFS_FAST_RC_CTRL, {28'h0, 2'(f), 2'b01}, "rc freq field");
         check({30'h0, int_rc_freq_select}, 32'(f), "rc freq pins");
      end
      wr(`OFS_FAST_XTAL_CTRL, 32'hfc);
      rchk(`OFS_FAST_XTAL_CTRL, 32'h4, "crystal mode");
      bchk(crystal_range_mode, 1'b1, "crystal mode pin");
      wr(`OFS_FAST_XTAL_CTRL, 32'h5);
      wr(`OFS_FAST_XTAL_CTRL, 32'h1);
      rchk(`OFS_FAST_XTAL_CTRL, 32'h5, "mode change while enabled");
      bchk(external_fast_crystal_run, 1'b1, "fast crystal run");
      wr(`OFS_SLOW_XTAL_CTRL, 32'hfd);
      tick_on <= 1'b1;
      repeat (8400) @(posedge hclk);
      bchk(irq, 1'b0, "masked irq");
      rchk(`OFS_FAST_RC_CTRL, 32'hf, "fast rc stable");
      rchk(`OFS_FAST_XTAL_CTRL, 32'h7, "fast crystal stable");
      rchk(`OFS_SLOW_XTAL_CTRL, 32'h3, "slow crystal stable");
      wr(`OFS_IRQ_MASK, 32'h2);
      rchk(`OFS_IRQ_MASK, 32'h2, "irq mask");
      bchk(irq, 1'b1, "irq raised");
      rchk(`OFS_IRQ_STATUS, 32'h7, "stable events");
      bchk(irq, 1'b0, "irq cleared by read");
      wr(`OFS_FAST_RC_CTRL, 32'hc);
      rchk(`OFS_FAST_RC_CTRL, 32'hc, "stable cleared on disable");
      wr(`OFS_FAST_RC_CTRL, 32'h1);
      rchk(`OFS_FAST_RC_CTRL, 32'h1, "stable low after enable");
      for (int k = 0; k < 7; k++)
         sysrate({k[2:0], 5'h0}, 32'd256 >> k);
      sysrate(8'h08, 32'd128);
      sysrate(8'he0, 32'd128);
      sysrate(8'he4, 32'd64);
      wr(`OFS_SYSCLK_SELECT, 32'h0);
      halt_active <= 1'b1;
      @(negedge hclk);
      bchk(deep_power_down, 1'b1, "deep power-down");
      bchk(internal_fast_rc_run, 1'b0, "fast rc halted");
      bchk(internal_slow_rc_run, 1'b0, "slow rc halted");
      bchk(external_slow_crystal_run, 1'b0, "slow crystal halted");
      @(posedge hclk);
      wdt_enable <= 1'b1;
      @(negedge hclk);
      bchk(internal_slow_rc_run, 1'b1, "slow rc kept by watchdog");
      @(posedge hclk);
      wr(`OFS_SYSCLK_SELECT, 32'h3);
      @(negedge hclk);
      bchk(internal_fast_rc_run, 1'b1, "fast rc kept");
      bchk(external_slow_crystal_run, 1'b1, "slow crystal kept");
      bchk(deep_power_down, 1'b0, "idle instead of deep");
      end_of_test;
   end
endmodule : test_system_clock_osc_control
